/* File: src/dbb_pkg.sv */
// package for the demultiplexed burst bus master: widths, codes and types.
// assumes one 25 MHz clock domain and a core-side request port.
package dbb_pkg;
    localparam int          DATA_W        = 32;
    localparam int          WADDR_W       = 30;
    localparam int          WAIT_W        = 5;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          FIFO_CNT_W    = 4;
    localparam logic [1:0]  WIDTH_8       = 2'h0;
    localparam logic [1:0]  WIDTH_16      = 2'h1;
    localparam logic [1:0]  WIDTH_32      = 2'h2;
    localparam logic [3:0]  OE_MASK_8     = 4'hE;
    localparam logic [3:0]  OE_MASK_16    = 4'hC;
    localparam logic [3:0]  OE_MASK_32    = 4'h0;
    localparam logic [3:0]  OE_ALL_OFF    = 4'hF;
    localparam logic [3:0]  LANES_IDLE_N  = 4'hF;
    localparam logic        DIR_RESET     = 1'h0;
    localparam logic [1:0]  WORD_STEP     = 2'h1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_SUSP
    } dbb_state_type;

    typedef struct packed {
        logic [31:0]       addr;      // byte address
        logic              is_read;
        logic [1:0]        width;     // region width code
        logic [3:0]        byte_en;   // active high byte enables
        logic [1:0]        beats_m1;  // words in burst minus one
        logic              ready_en;  // region honours the ready pin
        logic [WAIT_W-1:0] waits;     // programmed wait states per word
    } dbb_req_type;

    typedef struct packed {
        dbb_state_type      state;
        dbb_req_type        req;
        logic [1:0]         beat;
        logic [WAIT_W-1:0]  cnt;
        logic [WADDR_W-1:0] word_addr;
        logic [3:0]         lanes_n;
        logic               dir;
        logic               strobe_n;
        logic               final_n;
        logic               addr_oe_n;
        logic               lane_oe_n;
        logic               ctl_oe_n;
        logic               final_oe_n;
        logic [3:0]         data_oe_n;
        logic [DATA_W-1:0]  dout;
        logic [DATA_W-1:0]  rd_data;
        logic               rd_valid;
        logic               req_ready;
        logic               busy;
        logic               float_s1;
        logic               float_s2;
    } dbb_bus_state_type;
endpackage

/* File: src/dbb_bus_master.sv */
// write data FIFO and demultiplexed burst bus master (address, data,
// lane selects, direction, strobe, final transfer).
// assumes hold_backoff_in comes from arbitration logic on clk_sys_in;
// ready and data pins are synchronous, test_float_mode_in is not.
//
// How it works
// - test float mode releases every bus pin
// - outputs and samples move on system clock
// - hold or backoff floats address, data, control
// - reset floats buses, lanes high, direction low
// - bus carries word address, upper 30 bits
// - burst steps two low word-address bits
// - data lines used follow region width
// - 32-bit region: lane selects are byte enables
// - 16-bit region: high enable, A1, low enable
// - 8-bit region: lanes 1,0 carry A1,A0
// - direction high for reads, low for writes
// - direction changes only with the strobe
// - direction held valid through whole access
// - strobe low for first clock of access
// - ready sampled after waits, extends transfer
// - final transfer marked when wait count ends
`timescale 1ns/10ps
`default_nettype none

module dbb_fifo
    import dbb_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_in,    // system clock
    input  wire logic             rst_in,        // async reset, high
    input  wire logic             in_valid_in,   // push request
    output logic                  in_ready_out,  // room for a word
    input  wire logic [WIDTH-1:0] in_data_in,    // pushed word
    output logic                  out_valid_out, // head word present
    input  wire logic             out_ready_in,  // pop request
    output logic      [WIDTH-1:0] out_data_out,  // head word
    output logic      [WIDTH-1:0] out_next_out,  // word behind head
    output logic [FIFO_CNT_W-1:0] count_out      // words held
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0]      wr_ptr;
        logic [PTR_W-1:0]      rd_ptr;
        logic [FIFO_CNT_W-1:0] count;
        logic                  room;
    } dbb_fifo_state_type;

    dbb_fifo_state_type s_ff;
    dbb_fifo_state_type nxt_s;
    logic [WIDTH-1:0]   mem_ff [DEPTH];
    logic               push;
    logic               pop;

    assign push          = in_valid_in && s_ff.room;
    assign pop           = out_ready_in && (s_ff.count != '0);
    assign in_ready_out  = s_ff.room;
    assign out_valid_out = (s_ff.count != '0);
    assign out_data_out  = mem_ff[s_ff.rd_ptr];
    assign out_next_out  = mem_ff[PTR_W'(s_ff.rd_ptr + 1'b1)];
    assign count_out     = s_ff.count;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.wr_ptr = PTR_W'(s_ff.wr_ptr + 1'b1);
        end
        if (pop) begin
            nxt_s.rd_ptr = PTR_W'(s_ff.rd_ptr + 1'b1);
        end
        nxt_s.count = FIFO_CNT_W'(s_ff.count + push - pop);
        nxt_s.room  = (nxt_s.count != FIFO_CNT_W'(DEPTH));
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_ff[s_ff.wr_ptr] <= in_data_in;
        end
    end
endmodule // dbb_fifo

module dbb_bus_master
    import dbb_pkg::*;
(
    input  wire logic               clk_sys_in,        // 25 MHz clock
    input  wire logic               rst_in,            // async reset, high
    input  wire logic               req_valid_in,      // access request
    input  wire dbb_req_type        req_in,            // access descriptor
    output logic                    req_ready_out,     // may take request
    output logic                    busy_out,          // access running
    input  wire logic               wr_valid_in,       // write word valid
    input  wire logic [DATA_W-1:0]  wr_data_in,        // write word
    output logic                    wr_ready_out,      // FIFO has room
    output logic      [DATA_W-1:0]  rd_data_out,       // read word
    output logic                    rd_valid_out,      // read word pulse
    input  wire logic               hold_backoff_in,   // hold ack or backoff
    input  wire logic               test_float_mode_in,// pin: float all
    input  wire logic               ready_n_in,        // pin: ready, low
    output logic [WADDR_W-1:0]      word_address_bus_out,   // WORD_ADDRESS_BUS level
    output logic                    word_address_oe_n_out,  // addr enable
    input  wire logic [DATA_W-1:0]  bidir_data_bus_in,      // data pins in
    output logic      [DATA_W-1:0]  bidir_data_bus_out,     // data pins out
    output logic      [3:0]         bidir_data_bus_oe_n_out,// per byte
    output logic      [3:0]         lane_select_n_out,      // lane selects
    output logic                    lane_select_oe_n_out,   // lane enable
    output logic                    read_direction_out,     // high = read
    output logic                    address_strobe_n_out,   // strobe, low
    output logic                    control_oe_n_out,       // dir/strobe oe
    output logic                    final_transfer_n_out,   // last, low
    output logic                    final_transfer_oe_n_out // last oe
);
    dbb_bus_state_type s_ff;
    dbb_bus_state_type nxt_s;
    logic                  pop;
    logic                  beat_ok;
    logic                  data_ok;
    logic                  fifo_valid;
    logic [DATA_W-1:0]     fifo_head;
    logic [DATA_W-1:0]     fifo_next;
    logic [FIFO_CNT_W-1:0] fifo_count;
    logic [3:0]            cur_mask;
    logic [DATA_W-1:0]     rd_keep;

    dbb_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .in_valid_in   (wr_valid_in),
        .in_ready_out  (wr_ready_out),
        .in_data_in    (wr_data_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (pop),
        .out_data_out  (fifo_head),
        .out_next_out  (fifo_next),
        .count_out     (fifo_count)
    );

    function automatic logic [3:0] lanes_for(input logic [1:0] width,
                                             input logic [1:0] a,
                                             input logic [3:0] be);
        case (width)
            WIDTH_8:  lanes_for = {2'h3, a[1], a[0]};
            WIDTH_16: lanes_for = {~be[1], 1'b1, a[1], ~be[0]};
            default:  lanes_for = ~be;
        endcase
    endfunction

    function automatic logic [3:0] oe_mask(input logic [1:0] width);
        case (width)
            WIDTH_8:  oe_mask = OE_MASK_8;
            WIDTH_16: oe_mask = OE_MASK_16;
            default:  oe_mask = OE_MASK_32;
        endcase
    endfunction

    // ready is a synchronous pin, looked at only once the waits run out
    assign beat_ok = (s_ff.cnt == '0) &&
                     (!s_ff.req.ready_en || !ready_n_in);
    assign cur_mask = oe_mask(s_ff.req.width);
    for (genvar b = 0; b < 4; b++) begin : g_keep
        assign rd_keep[8*b +: 8] = {8{~cur_mask[b]}};
    end
    // a write starts only with all of its words already buffered
    assign data_ok = req_in.is_read ||
                     (fifo_count >= FIFO_CNT_W'({2'h0, req_in.beats_m1} + 1));

    always_comb begin
        nxt_s          = s_ff;
        pop            = 1'b0;
        nxt_s.float_s1 = test_float_mode_in;
        nxt_s.float_s2 = s_ff.float_s1;
        nxt_s.rd_valid = 1'b0;
        nxt_s.strobe_n = 1'b1;
        case (s_ff.state)
            ST_IDLE: begin
                if (req_valid_in && s_ff.req_ready && data_ok) begin
                    nxt_s.req       = req_in;
                    nxt_s.beat      = '0;
                    nxt_s.word_addr = req_in.addr[31:2];
                    nxt_s.dir       = req_in.is_read;
                    nxt_s.lanes_n   = lanes_for(req_in.width,
                                                req_in.addr[1:0],
                                                req_in.byte_en);
                    nxt_s.cnt       = req_in.waits;
                    nxt_s.strobe_n  = 1'b0;
                    nxt_s.dout      = fifo_head;
                    nxt_s.state     = ST_ADDR;
                end
            end
            ST_ADDR: begin
                nxt_s.state = hold_backoff_in ? ST_SUSP : ST_DATA;
            end
            ST_DATA: begin
                if (hold_backoff_in) begin
                    nxt_s.state = ST_SUSP;
                end else if (s_ff.cnt != '0) begin
                    nxt_s.cnt = WAIT_W'(s_ff.cnt - 1'b1);
                end else if (beat_ok) begin
                    if (s_ff.req.is_read) begin
                        nxt_s.rd_data  = bidir_data_bus_in & rd_keep;
                        nxt_s.rd_valid = 1'b1;
                    end else begin
                        pop = fifo_valid;
                    end
                    if (s_ff.beat == s_ff.req.beats_m1) begin
                        nxt_s.state = ST_IDLE;
                    end else begin
                        nxt_s.beat = s_ff.beat + 2'h1;
                        // only the two low word bits move
                        nxt_s.word_addr[1:0] = s_ff.word_addr[1:0] +
                                               WORD_STEP;
                        nxt_s.cnt  = s_ff.req.waits;
                        nxt_s.dout = fifo_next;
                    end
                end
            end
            ST_SUSP: begin
                // backoff resumes with a fresh strobe on the same word
                if (!hold_backoff_in) begin
                    nxt_s.strobe_n = 1'b0;
                    nxt_s.cnt      = s_ff.req.waits;
                    nxt_s.state    = ST_ADDR;
                end
            end
            default: begin
                nxt_s.state = ST_IDLE;
            end
        endcase
        nxt_s.final_n    = !(nxt_s.state == ST_DATA &&
                             nxt_s.beat == nxt_s.req.beats_m1 &&
                             nxt_s.cnt == '0);
        nxt_s.addr_oe_n  = s_ff.float_s2 || hold_backoff_in;
        nxt_s.lane_oe_n  = s_ff.float_s2 || hold_backoff_in;
        nxt_s.ctl_oe_n   = s_ff.float_s2 || hold_backoff_in;
        nxt_s.final_oe_n = s_ff.float_s2 || hold_backoff_in;
        if (s_ff.float_s2 || hold_backoff_in || nxt_s.req.is_read ||
            !(nxt_s.state == ST_ADDR || nxt_s.state == ST_DATA)) begin
            nxt_s.data_oe_n = OE_ALL_OFF;
        end else begin
            nxt_s.data_oe_n = oe_mask(nxt_s.req.width);
        end
        nxt_s.busy      = (nxt_s.state != ST_IDLE);
        nxt_s.req_ready = (nxt_s.state == ST_IDLE) && !s_ff.float_s2;
    end

    // direction is left alone between accesses, so it stays valid
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_ff            <= '0;
            s_ff.state      <= ST_IDLE;
            s_ff.lanes_n    <= LANES_IDLE_N;
            s_ff.dir        <= DIR_RESET;
            s_ff.strobe_n   <= 1'b1;
            s_ff.final_n    <= 1'b1;
            s_ff.addr_oe_n  <= 1'b1;
            s_ff.data_oe_n  <= OE_ALL_OFF;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign req_ready_out           = s_ff.req_ready;
    assign busy_out                = s_ff.busy;
    assign rd_data_out             = s_ff.rd_data;
    assign rd_valid_out            = s_ff.rd_valid;
    assign word_address_bus_out    = s_ff.word_addr;
    assign word_address_oe_n_out   = s_ff.addr_oe_n;
    assign bidir_data_bus_out      = s_ff.dout;
    assign bidir_data_bus_oe_n_out = s_ff.data_oe_n;
    assign lane_select_n_out       = s_ff.lanes_n;
    assign lane_select_oe_n_out    = s_ff.lane_oe_n;
    assign read_direction_out      = s_ff.dir;
    assign address_strobe_n_out    = s_ff.strobe_n;
    assign control_oe_n_out        = s_ff.ctl_oe_n;
    assign final_transfer_n_out    = s_ff.final_n;
    assign final_transfer_oe_n_out = s_ff.final_oe_n;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    AST_FLOAT_ALL: assert property (
        s_ff.float_s2 |=> word_address_oe_n_out && lane_select_oe_n_out &&
            control_oe_n_out && final_transfer_oe_n_out &&
            bidir_data_bus_oe_n_out == OE_ALL_OFF)
        else $error("pins driven in float mode");
    AST_HOLD_FLOAT: assert property (
        hold_backoff_in |=> word_address_oe_n_out && lane_select_oe_n_out &&
            control_oe_n_out && bidir_data_bus_oe_n_out == OE_ALL_OFF)
        else $error("pins driven during hold or backoff");
    AST_WORD_ADDR: assert property (
        (s_ff.state == ST_ADDR && s_ff.beat == 2'h0) |->
            word_address_bus_out == s_ff.req.addr[31:2])
        else $error("first word address wrong");
    AST_BURST_STEP: assert property (
        (s_ff.state == ST_DATA && beat_ok && !hold_backoff_in &&
         s_ff.beat != s_ff.req.beats_m1) |=>
            word_address_bus_out[1:0] ==
            $past(word_address_bus_out[1:0]) + WORD_STEP)
        else $error("burst word address did not step");
    AST_BLOCK_KEEP: assert property (
        (s_ff.state == ST_DATA && $past(s_ff.state) == ST_DATA) |->
            $stable(word_address_bus_out[WADDR_W-1:2]))
        else $error("burst left its four-word block");
    AST_DATA_LINES: assert property (
        (bidir_data_bus_oe_n_out != OE_ALL_OFF) |->
            bidir_data_bus_oe_n_out == oe_mask(s_ff.req.width) &&
            !read_direction_out)
        else $error("data lines do not match region width");
    AST_LANE_32: assert property (
        (s_ff.busy && s_ff.req.width == WIDTH_32) |->
            lane_select_n_out == ~s_ff.req.byte_en)
        else $error("32-bit lane selects wrong");
    AST_LANE_16: assert property (
        (s_ff.busy && s_ff.req.width == WIDTH_16) |->
            lane_select_n_out[3] == !s_ff.req.byte_en[1] &&
            lane_select_n_out[1] == s_ff.req.addr[1] &&
            lane_select_n_out[0] == !s_ff.req.byte_en[0])
        else $error("16-bit lane selects wrong");
    AST_LANE_8: assert property (
        (s_ff.busy && s_ff.req.width == WIDTH_8) |->
            lane_select_n_out[1:0] == s_ff.req.addr[1:0])
        else $error("8-bit lane selects wrong");
    AST_DIR_READ: assert property (
        s_ff.busy |-> read_direction_out == s_ff.req.is_read)
        else $error("direction does not match request");
    AST_DIR_MOVE: assert property (
        $changed(read_direction_out) |-> !address_strobe_n_out)
        else $error("direction moved without strobe");
    AST_STROBE_ONE: assert property (
        !address_strobe_n_out |=> address_strobe_n_out && s_ff.busy)
        else $error("strobe longer than one clock");
    AST_READY_WAIT: assert property (
        (s_ff.state == ST_DATA && s_ff.cnt == '0 && s_ff.req.ready_en &&
         ready_n_in && !hold_backoff_in) |=>
            s_ff.state == ST_DATA && $stable(s_ff.beat) && !rd_valid_out)
        else $error("transfer ended without ready");
    AST_FINAL_LAST: assert property (
        (s_ff.state == ST_DATA && s_ff.beat == s_ff.req.beats_m1 &&
         s_ff.cnt == '0) |-> !final_transfer_n_out)
        else $error("final transfer not marked");

    COV_READ_BURST: cover property (
        s_ff.state == ST_DATA && s_ff.req.is_read &&
        s_ff.req.beats_m1 == 2'h3 ##1 s_ff.state == ST_IDLE);
    COV_WRITE_DONE: cover property (
        pop && s_ff.beat == s_ff.req.beats_m1);
    COV_BACKOFF: cover property (
        s_ff.state == ST_SUSP ##1 s_ff.state == ST_ADDR);
    COV_READY_STALL: cover property (
        s_ff.state == ST_DATA && s_ff.cnt == '0 && s_ff.req.ready_en &&
        ready_n_in);
endmodule // dbb_bus_master

`default_nettype wire

/* File: tb/dbb_mem_model.sv */
// far-side memory model: 16 words indexed by the low word-address bits.
// assumes the master samples ready and read data on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dbb_mem_model
    import dbb_pkg::*;
(
    input  wire logic               clk_sys_in,   // system clock
    input  wire logic [WADDR_W-1:0] addr_in,      // word address pins
    input  wire logic               addr_oe_n_in, // address driven, low
    input  wire logic               dir_in,       // high = read
    input  wire logic               strobe_n_in,  // access start, low
    input  wire logic [DATA_W-1:0]  dout_in,      // master data out
    input  wire logic [3:0]         doe_n_in,     // master lane enables
    input  wire logic [3:0]         stall_in,     // ready delay in clocks
    output logic                    ready_n_out,  // ready, low
    output logic      [DATA_W-1:0]  din_out       // resolved data pins
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last = 32'h0;
    logic [3:0]        cnt  = 4'hF;
    logic              drv;
    initial for (int i = 0; i < 16; i++) mem[i] = {28'hA1B2C3D, i[3:0]};
    assign drv = !addr_oe_n_in && dir_in;
    assign ready_n_out = (cnt < stall_in);
    always @(posedge clk_sys_in) begin
        cnt  <= !strobe_n_in ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
        last <= din_out;
        for (int b = 0; b < 4; b++)
            if (!doe_n_in[b] && !addr_oe_n_in)
                mem[addr_in[3:0]][8*b +: 8] <= dout_in[8*b +: 8];
    end
    // released lanes show memory data while a read drives the address, else the inverse of their last level
    always_comb begin
        for (int b = 0; b < 4; b++)
            din_out[8*b +: 8] = !doe_n_in[b] ? dout_in[8*b +: 8] :
                drv ? mem[addr_in[3:0]][8*b +: 8] : ~last[8*b +: 8];
    end
endmodule // dbb_mem_model
`default_nettype wire

/* File: tb/tb_dbb_bus_master.sv */
// self-checking bench for the burst bus master and its write FIFO.
// assumes the far-side memory model of dbb_mem_model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_dbb_bus_master
    import dbb_pkg::*;
();
    logic clk_sys_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0;
    logic wr_valid_in = 1'b0, hold_backoff_in = 1'b0;
    logic test_float_mode_in = 1'b0, ready_n_in, wr_ready_out;
    logic req_ready_out, busy_out, rd_valid_out, word_address_oe_n_out;
    logic lane_select_oe_n_out, read_direction_out, address_strobe_n_out;
    logic control_oe_n_out, final_transfer_n_out, final_transfer_oe_n_out;
    dbb_req_type req_in = '0;
    logic [DATA_W-1:0] wr_data_in = '0, rd_data_out, bidir_data_bus_in;
    logic [DATA_W-1:0] bidir_data_bus_out;
    logic [WADDR_W-1:0] word_address_bus_out;
    logic [3:0] bidir_data_bus_oe_n_out, lane_select_n_out, lanes, doe;
    logic [3:0] stall = 4'h0;
    int mismatches = 0, check_count = 0, n_stb, cyc, fin_at, dir_bad, n;
    logic [WADDR_W-1:0] aq[$];
    logic [DATA_W-1:0] rq[$];
    dbb_bus_master dut (.clk_sys_in, .rst_in, .req_valid_in, .req_in,
        .req_ready_out, .busy_out, .wr_valid_in, .wr_data_in, .wr_ready_out,
        .rd_data_out, .rd_valid_out, .hold_backoff_in, .test_float_mode_in,
        .ready_n_in, .word_address_bus_out, .word_address_oe_n_out,
        .bidir_data_bus_in, .bidir_data_bus_out, .bidir_data_bus_oe_n_out,
        .lane_select_n_out, .lane_select_oe_n_out, .read_direction_out,
        .address_strobe_n_out, .control_oe_n_out, .final_transfer_n_out,
        .final_transfer_oe_n_out);
    dbb_mem_model mem (.clk_sys_in, .addr_in(word_address_bus_out),
        .addr_oe_n_in(word_address_oe_n_out), .dir_in(read_direction_out),
        .strobe_n_in(address_strobe_n_out), .dout_in(bidir_data_bus_out),
        .doe_n_in(bidir_data_bus_oe_n_out), .stall_in(stall),
        .ready_n_out(ready_n_in), .din_out(bidir_data_bus_in));
    initial forever #20 clk_sys_in = ~clk_sys_in;
    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic bail;
        mismatches++;
        report_and_stop();
    endtask
    function automatic dbb_req_type mk(logic [31:0] a, logic rd,
        logic [1:0] w, logic [3:0] be, logic [1:0] bm, logic re,
        logic [4:0] ws);
        mk = '{a, rd, w, be, bm, re, ws};
    endfunction
    // present one request, then log every cycle of the access
    task automatic run(input dbb_req_type r, input int hold_at);
        @(posedge clk_sys_in) begin req_valid_in <= 1'b1; req_in <= r; end
        n = 0;
        do begin @(posedge clk_sys_in); #1; n++; end
        while (!busy_out && n < 30);
        if (!busy_out) bail();
        req_valid_in <= 1'b0;
        {n_stb, cyc, dir_bad, fin_at} = {32'd0, 32'd0, 32'd0, -32'sd1};
        aq.delete();
        rq.delete();
        while (busy_out && cyc < 80) begin
            if (!address_strobe_n_out) begin
                n_stb++;
                lanes = lane_select_n_out;
                doe = bidir_data_bus_oe_n_out;
            end
            if (!control_oe_n_out && read_direction_out !== r.is_read)
                dir_bad++;
            if (!final_transfer_n_out && !final_transfer_oe_n_out)
                fin_at = cyc;
            if (!word_address_oe_n_out && (aq.size() == 0 ||
                aq[$] !== word_address_bus_out))
                aq.push_back(word_address_bus_out);
            if (cyc == hold_at) hold_backoff_in <= 1'b1;
            if (cyc == hold_at + 1) begin
                `CHK("hold oe", 7'h7F, {word_address_oe_n_out,
                    lane_select_oe_n_out, control_oe_n_out,
                    bidir_data_bus_oe_n_out})
                hold_backoff_in <= 1'b0;
            end
            @(posedge clk_sys_in); #1; cyc++;
            if (rd_valid_out) rq.push_back(rd_data_out);
        end
        if (busy_out) bail();
    endtask
    task automatic push(input int k0);
        wr_valid_in <= 1'b1;
        wr_data_in <= 32'hC0DEA5B0 + k0;
        n = 0;
        repeat (12) if (wr_ready_out) begin
            @(posedge clk_sys_in); #1; n++;
            wr_data_in <= 32'hC0DEA5B0 + k0 + n;
        end
        wr_valid_in <= 1'b0;
    endtask
    task automatic sc_reset;
        @(posedge clk_sys_in); #1;
        `CHK("rst pins", 8'hFA, {word_address_oe_n_out,
            bidir_data_bus_oe_n_out, read_direction_out,
            address_strobe_n_out, control_oe_n_out})
        `CHK("rst lanes", 5'h1E, {lane_select_n_out, lane_select_oe_n_out})
    endtask
    task automatic sc_read32;
        run(mk(32'h1008, 1, WIDTH_32, 4'h6, 2'h0, 0, 5'h3), -9);
        `CHK("strobes", 1, n_stb)
        `CHK("cycles", 5, cyc)
        `CHK("final", 4, fin_at)
        `CHK("addr", 30'h402, aq[0])
        `CHK("lanes32", 4'h9, lanes)
        `CHK("dir", 0, dir_bad)
        `CHK("rd doe", 4'hF, doe)
        `CHK("rd data", 32'hA1B2C3D2, rq[0])
    endtask
    task automatic sc_burst;
        push(0);
        `CHK("fifo fill", 8, n)
        `CHK("fifo full", 1'b0, wr_ready_out)
        run(mk(32'h1008, 0, WIDTH_32, 4'hF, 2'h3, 0, 5'h0), -9);
        `CHK("wr doe", 4'h0, doe)
        `CHK("wr dir", 0, dir_bad)
        for (int k = 0; k < 4; k++)
            `CHK("burst addr", 30'h400 + ((k + 2) % 4), aq[k])
        run(mk(32'h1010, 0, WIDTH_32, 4'hF, 2'h3, 0, 5'h1), -9);
        `CHK("fifo drained", 1'b1, wr_ready_out)
        run(mk(32'h1008, 1, WIDTH_32, 4'hF, 2'h3, 0, 5'h0), -9);
        `CHK("beats", 4, rq.size())
        for (int k = 0; k < 4; k++)
            `CHK("burst data", 32'hC0DEA5B0 + k, rq[k])
    endtask
    task automatic sc_narrow;
        run(mk(32'h100A, 1, WIDTH_16, 4'h1, 2'h0, 0, 5'h0), -9);
        `CHK("lanes16", 4'hA, lanes & 4'hB)
        `CHK("rd16", 32'h0000A5B0, rq[0])
        run(mk(32'h1012, 1, WIDTH_8, 4'h1, 2'h0, 0, 5'h0), -9);
        `CHK("lanes8", 2'h2, lanes[1:0])
        `CHK("rd8", 32'h000000B4, rq[0])
        push(8);
        run(mk(32'h1003, 0, WIDTH_8, 4'h1, 2'h0, 0, 5'h0), -9);
        `CHK("wr8 doe", 4'hE, doe)
        `CHK("wr8 lanes", 2'h3, lanes[1:0])
    endtask
    task automatic sc_hold_ready;
        run(mk(32'h1008, 1, WIDTH_32, 4'hF, 2'h0, 0, 5'h4), 2);
        `CHK("resume strobe", 2, n_stb)
        `CHK("resume data", 32'hC0DEA5B0, rq[0])
        stall <= 4'h6;
        run(mk(32'h1008, 1, WIDTH_32, 4'hF, 2'h0, 1, 5'h0), -9);
        `CHK("ready wait", 1'b1, cyc > 6)
        `CHK("final held", cyc - 1, fin_at)
        stall <= 4'h0;
    endtask
    task automatic sc_float;
        @(posedge clk_sys_in) test_float_mode_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1;
        `CHK("float", 9'h1FE, {word_address_oe_n_out,
            lane_select_oe_n_out, control_oe_n_out, final_transfer_oe_n_out,
            bidir_data_bus_oe_n_out, req_ready_out})
        test_float_mode_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
    endtask
    initial begin
        sc_reset();
        @(posedge clk_sys_in) rst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        sc_read32();
        sc_burst();
        sc_narrow();
        sc_hold_ready();
        sc_float();
        report_and_stop();
    end
endmodule // tb_dbb_bus_master
`default_nettype wire
